// >>> verilog/pcfh_defs.vh
// Purpose: Constants for the function 0 configuration header block
// Assumes: Dword register index from the configuration address phase
// Notes: Definitions only
`ifndef PCFH_DEFS_VH
`define PCFH_DEFS_VH
`define PCFH_IDX_W 6
`define PCFH_REG_ID 6'h00
`define PCFH_REG_CMDSTAT 6'h01
`define PCFH_HDR_LAST 6'h0F
`define PCFH_VENDOR_CODE 16'h1234
`define PCFH_DEVICE_BASE 12'hABC
`define PCFH_CMD_IO 0
`define PCFH_CMD_MEM 1
`define PCFH_CMD_MASTER 2
`define PCFH_CMD_PERR_RSP 6
`define PCFH_CMD_SERR_DIS 8
`define PCFH_CMD_FBB 9
`define PCFH_CMD_RW_MASK 16'h0346
`define PCFH_CMD_RW_LO 8'h46
`define PCFH_CMD_RW_HI 8'h03
`define PCFH_VAR_32CH 2'h0
`define PCFH_VAR_64CH 2'h1
`define PCFH_VAR_128CH 2'h2
`define PCFH_DIGIT_32CH 4'h1
`define PCFH_DIGIT_64CH 4'h2
`define PCFH_DIGIT_128CH 4'h4
`define PCFH_DIGIT_256CH 4'h8
`define PCFH_ST_66MHZ 21
`define PCFH_ST_FBB 23
`define PCFH_ST_DPD 24
`define PCFH_ST_DEVSEL_LO 25
`define PCFH_ST_DEVSEL_HI 26
`define PCFH_ST_RTA 28
`define PCFH_ST_RMA 29
`define PCFH_ST_SSE 30
`define PCFH_ST_DPE 31
`define PCFH_DEVSEL_MEDIUM 2'h1
`define PCFH_DEVSEL_MAX_CLK 3
`endif

// >>> verilog/pcfh_sticky.v
// Purpose: One write-one-to-clear status flag
// Assumes: Event and clear come from the same clock
// Notes: Set wins over a clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module pcfh_sticky (
  input wire clk,
  input wire sys_rst,
  input wire set_evt,
  input wire clr_req,
  output reg flag_r
);
  // Sticky flag, cleared by a one written from software
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_r <= 1'b0;
    end else if (set_evt) begin
      flag_r <= 1'b1;
    end else if (clr_req) begin
      flag_r <= 1'b0;
    end
  end
endmodule // pcfh_sticky
`default_nettype wire

// >>> verilog/pcfh_rdmux.v
// Purpose: Read data selection for the configuration header
// Assumes: Register index already qualified by the caller
// Notes: Unmapped indices read zero
`timescale 1ns/1ps
`default_nettype none
`include "pcfh_defs.vh"
module pcfh_rdmux (
  input wire [`PCFH_IDX_W-1:0] reg_idx,
  input wire [31:0] id_word,
  input wire [31:0] cmdstat_word,
  output reg [31:0] rd_word
);
  // Only two dwords carry content; the rest of space reads zero
  always @* begin
    case (reg_idx)
      `PCFH_REG_ID: rd_word = id_word;
      `PCFH_REG_CMDSTAT: rd_word = cmdstat_word;
      default: rd_word = 32'h00000000;
    endcase
  end
endmodule // pcfh_rdmux
`default_nettype wire

// >>> verilog/pcfh_config_header.v
// Purpose: Function 0 configuration header, identification and
//   command/status dwords, with the rest of the space reading zero
// Assumes: Target decode already qualified the configuration cycle;
//   bus event strobes are one-cycle pulses on the PCI clock
// Notes: Device code low digit chosen by the channel_variant input
// Behaviour
// - Only the 64-byte header region exists
// - Dependent region reads zero, ignores writes
// - Read-only bits fixed, reserved read zero
// - Status flags clear on written one only
// - Read/write bits return last written value
// - Sixteen dwords chosen by register index
// - Dword 0 holds device and vendor codes
// - Reset clears command bits, config only
// - Bit 31 on target data parity error
// - Bit 30 whenever system error asserted
// - Bit 29 on master abort received
// - Bit 28 on target abort received
// - Medium select timing, within three clocks
// - Bit 24 needs parity, master, response enable
// - Bit 23 reads one, fast back-to-back
// - Bit 21 reads one on later revisions
// - Command bit 6 gates parity reaction
// - Command bit 8 disables system error driver
`timescale 1ns/1ps
`default_nettype none
`include "pcfh_defs.vh"
module pcfh_config_header (
  input wire clk,
  input wire sys_rst,
  input wire cfg_rd,
  input wire cfg_wr,
  input wire [`PCFH_IDX_W-1:0] cfg_idx,
  input wire [3:0] cfg_be,
  input wire [31:0] cfg_wdata,
  output reg [31:0] cfg_rdata,
  output reg cfg_rvalid,
  input wire [1:0] channel_variant,
  input wire rev_66mhz,
  input wire tgt_data_perr,
  input wire mst_perr_seen,
  input wire serr_request,
  input wire mst_abort_evt,
  input wire tgt_abort_evt,
  output wire serr_drive,
  output wire perr_react_en,
  output wire mem_space_en,
  output wire bus_master_en
);
  reg [15:0] cmd_r;
  reg [15:0] cmd_nxt;
  reg [3:0] dev_digit;
  wire [31:0] id_word;
  wire [31:0] cmdstat_word;
  wire [31:0] rd_word;
  wire [15:0] status_word;
  wire hdr_hit;
  wire wr_cs;
  wire [1:0] clr_hi;
  wire dpe_q, sse_q, rma_q, rta_q, dpd_q;
  wire dpd_evt;

  // Index range check; anything past dword 15 is the dependent region
  function in_header;
    input [`PCFH_IDX_W-1:0] idx;
    begin
      in_header = (idx <= `PCFH_HDR_LAST);
    end
  endfunction

  assign hdr_hit = in_header(cfg_idx);
  // Dependent-region writes fall out here and touch nothing
  assign wr_cs = cfg_wr && hdr_hit &&
    (cfg_idx == `PCFH_REG_CMDSTAT);

  // Low digit of the device code follows channel count 32/64/128/256
  always @* begin
    case (channel_variant)
      `PCFH_VAR_32CH: dev_digit = `PCFH_DIGIT_32CH;
      `PCFH_VAR_64CH: dev_digit = `PCFH_DIGIT_64CH;
      `PCFH_VAR_128CH: dev_digit = `PCFH_DIGIT_128CH;
      default: dev_digit = `PCFH_DIGIT_256CH;
    endcase
  end

  // Identification codes, not writable by any cycle
  assign id_word = {`PCFH_DEVICE_BASE, dev_digit,
    `PCFH_VENDOR_CODE};

  // Only the writable command bits take new data, per byte lane
  always @* begin
    cmd_nxt = cmd_r;
    if (wr_cs) begin
      if (cfg_be[0]) begin
        cmd_nxt[7:0] = cfg_wdata[7:0] & `PCFH_CMD_RW_LO;
      end
      if (cfg_be[1]) begin
        // Per-lane masks keep the widths matched lane by lane
        cmd_nxt[15:8] = cfg_wdata[15:8] & `PCFH_CMD_RW_HI;
      end
    end
  end

  // Reset leaves the block answering configuration cycles only
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_r <= 16'h0000;
    end else begin
      cmd_r <= cmd_nxt;
    end
  end

  // Upper status lane clears flags where a one is written
  assign clr_hi = {wr_cs && cfg_be[3], wr_cs && cfg_be[3]};

  // Master data parity only counts with response enabled
  assign dpd_evt = mst_perr_seen &&
    cmd_r[`PCFH_CMD_PERR_RSP];
  // Driver gated by inverted disable bit, so flag tracks real assertion
  assign serr_drive = serr_request &&
    !cmd_r[`PCFH_CMD_SERR_DIS];
  assign perr_react_en = cmd_r[`PCFH_CMD_PERR_RSP];
  assign mem_space_en = cmd_r[`PCFH_CMD_MEM];
  assign bus_master_en = cmd_r[`PCFH_CMD_MASTER];

  // Data parity on target side sets regardless of response enable
  pcfh_sticky u_dpe (
    .clk(clk), .sys_rst(sys_rst), .set_evt(tgt_data_perr),
    .clr_req(clr_hi[1] && cfg_wdata[`PCFH_ST_DPE]),
    .flag_r(dpe_q));
  pcfh_sticky u_sse (
    .clk(clk), .sys_rst(sys_rst), .set_evt(serr_drive),
    .clr_req(clr_hi[1] && cfg_wdata[`PCFH_ST_SSE]),
    .flag_r(sse_q));
  pcfh_sticky u_rma (
    .clk(clk), .sys_rst(sys_rst), .set_evt(mst_abort_evt),
    .clr_req(clr_hi[1] && cfg_wdata[`PCFH_ST_RMA]),
    .flag_r(rma_q));
  pcfh_sticky u_rta (
    .clk(clk), .sys_rst(sys_rst), .set_evt(tgt_abort_evt),
    .clr_req(clr_hi[1] && cfg_wdata[`PCFH_ST_RTA]),
    .flag_r(rta_q));
  pcfh_sticky u_dpd (
    .clk(clk), .sys_rst(sys_rst), .set_evt(dpd_evt),
    .clr_req(clr_hi[1] && cfg_wdata[`PCFH_ST_DPD]),
    .flag_r(dpd_q));

  // Status half: flags, fixed capability bits, reserved zeros
  assign status_word = {dpe_q, sse_q, rma_q, rta_q, 1'b0,
    `PCFH_DEVSEL_MEDIUM,
    dpd_q,
    1'b1,
    1'b0,
    rev_66mhz,
    5'h00};
  assign cmdstat_word = {status_word, cmd_r};

  pcfh_rdmux u_rdmux (
    .reg_idx(cfg_idx),
    .id_word(id_word),
    .cmdstat_word(cmdstat_word),
    .rd_word(rd_word)
  );

  // Registered read return, one clock after the request; well inside
  // the three-clock select window a medium device must keep
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_rdata <= 32'h00000000;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_rd;
      cfg_rdata <= (cfg_rd && hdr_hit) ? rd_word :
        32'h00000000;
    end
  end
endmodule // pcfh_config_header
`default_nettype wire

// >>> tb/pcfh_config_header_properties.sv
// Purpose: Port-level properties of the config header
// Assumes: Requests and events on the same clock
// Notes: Bound to the header module below
`timescale 1ns/1ps
`default_nettype none
module pcfh_config_header_properties (
  input wire clk, input wire sys_rst, input wire cfg_rd, input wire cfg_wr,
  input wire [5:0] cfg_idx, input wire [3:0] cfg_be,
  input wire [31:0] cfg_wdata, input wire [31:0] cfg_rdata,
  input wire cfg_rvalid, input wire [1:0] channel_variant,
  input wire rev_66mhz, input wire serr_request, input wire serr_drive,
  input wire perr_react_en, input wire mem_space_en, input wire bus_master_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Command enables seen as one vector
  wire [2:0] en = {perr_react_en, mem_space_en, bus_master_en};
  wire cmd_wr = cfg_wr && cfg_idx == 6'h01 && cfg_be[0];
  property p_rvalid; cfg_rvalid == $past(cfg_rd); endproperty
  a_rvalid: assert property (p_rvalid) else $error("late read");
  property p_nord; !cfg_rvalid |-> cfg_rdata == 32'h0; endproperty
  a_nord: assert property (p_nord) else $error("idle data");
  property p_hi; cfg_rd && cfg_idx > 6'h0F |=> cfg_rdata == 32'h0; endproperty
  a_hi: assert property (p_hi) else $error("high index data");
  property p_id; cfg_rd && cfg_idx == 6'h00 |=> cfg_rdata ==
    {12'hABC, 4'h1 << $past(channel_variant), 16'h1234}; endproperty
  a_id: assert property (p_id) else $error("bad id word");
  property p_fix; cfg_rd && cfg_idx == 6'h01 |=> (cfg_rdata & 32'h0EFFFCB9)
    == {7'h01, 3'b010, $past(rev_66mhz), 21'h0}; endproperty
  a_fix: assert property (p_fix) else $error("fixed bits");
  property p_wr; cmd_wr |=> en == {$past(cfg_wdata[6]),
    $past(cfg_wdata[1]), $past(cfg_wdata[2])}; endproperty
  a_wr: assert property (p_wr) else $error("command write");
  property p_hold; !cmd_wr |=> $stable(en); endproperty
  a_hold: assert property (p_hold) else $error("enables moved");
  property p_serr; serr_drive |-> serr_request; endproperty
  a_serr: assert property (p_serr) else $error("stray drive");
endmodule // pcfh_config_header_properties
bind pcfh_config_header pcfh_config_header_properties u_props (
  .clk(clk), .sys_rst(sys_rst), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
  .cfg_idx(cfg_idx), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
  .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
  .channel_variant(channel_variant), .rev_66mhz(rev_66mhz),
  .serr_request(serr_request), .serr_drive(serr_drive),
  .perr_react_en(perr_react_en), .mem_space_en(mem_space_en),
  .bus_master_en(bus_master_en));
`default_nettype wire

// >>> tb/pcfh_host_model.sv
// Purpose: Host side issuing configuration cycles
// Assumes: Fixed one-cycle read answer
// Notes: Released lines show inverted data
`timescale 1ns/1ps
`default_nettype none
module pcfh_host_model (
  input wire clk, output logic cfg_rd, output logic cfg_wr,
  output logic [5:0] cfg_idx, output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata, input wire [31:0] cfg_rdata,
  input wire cfg_rvalid
);
  initial {cfg_rd, cfg_wr, cfg_idx, cfg_be, cfg_wdata} = '0;
  // Request held over one edge, then lines scrambled
  task automatic go(input r, input [5:0] i, input [3:0] b, input [31:0] d);
    @(posedge clk) #1;
    {cfg_rd, cfg_wr, cfg_idx, cfg_be, cfg_wdata} = {r, !r, i, b, d};
    @(posedge clk) #1;
    {cfg_rd, cfg_wr} = 2'b00;
    {cfg_idx, cfg_be, cfg_wdata} = ~{cfg_idx, cfg_be, cfg_wdata};
  endtask
  task automatic rd(input [5:0] i, output [32:0] q);
    go(1'b1, i, 4'h0, 32'h0);
    q = {cfg_rvalid, cfg_rdata};
  endtask
endmodule // pcfh_host_model
`default_nettype wire

// >>> tb/pcfh_config_header_test.sv
// Purpose: Register-level test of the config header
// Assumes: Host model drives all configuration cycles
// Notes: Events pulsed one cycle each
`timescale 1ns/1ps
`default_nettype none
`include "pcfh_defs.vh"
module pcfh_config_header_test;
  logic clk = 0, sys_rst = 1, rev = 1;
  logic [1:0] vsel = 0;
  logic [4:0] ev = 0;
  logic [32:0] r;
  logic [5:0] tab [4] = '{6'h02, 6'h0F, 6'h10, 6'h3F};
  wire rd, wr, rv, serr, p_en, m_en, b_en;
  wire [5:0] idx;
  wire [3:0] be;
  wire [31:0] wd, rdat;
  int failures = 0, comparisons = 0;
  always #50 clk = ~clk;
  pcfh_host_model u_host (.clk(clk), .cfg_rd(rd), .cfg_wr(wr), .cfg_idx(idx),
    .cfg_be(be), .cfg_wdata(wd), .cfg_rdata(rdat), .cfg_rvalid(rv));
  pcfh_config_header DUT (.clk(clk), .sys_rst(sys_rst), .cfg_rd(rd),
    .cfg_wr(wr), .cfg_idx(idx), .cfg_be(be), .cfg_wdata(wd),
    .cfg_rdata(rdat), .cfg_rvalid(rv), .channel_variant(vsel),
    .rev_66mhz(rev), .tgt_data_perr(ev[4]), .serr_request(ev[3]),
    .mst_abort_evt(ev[2]), .tgt_abort_evt(ev[1]), .mst_perr_seen(ev[0]),
    .serr_drive(serr), .perr_react_en(p_en), .mem_space_en(m_en),
    .bus_master_en(b_en));
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rc(input [5:0] i, input [31:0] e);
    u_host.rd(i, r);
    chk(r, {1'b1, e});
  endtask
  // Event burst; system error line checked mid-pulse
  task automatic pulse(input [4:0] e, input s);
    @(posedge clk) #1 ev = e;
    #10 chk(serr, s);
    @(posedge clk) #1 ev = 0;
  endtask
  task automatic wrap_up;
    if (failures == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1 sys_rst = 0;
    rc(6'h01, 32'h02A00000);
    for (int v = 0; v < 4; v++) begin
      vsel = v[1:0];
      rc(6'h00, {`PCFH_DEVICE_BASE, 4'h1 << v, `PCFH_VENDOR_CODE});
    end
    u_host.go(0, 6'h01, 4'hF, 32'hFFFFFFFF);
    rc(6'h01, 32'h02A00346);
    chk({p_en, m_en, b_en}, 3'b111);
    u_host.go(0, 6'h01, 4'h3, 32'h00000046);
    pulse(5'h1F, 1);
    rc(6'h01, 32'hF3A00046);
    u_host.go(0, 6'h01, 4'h8, 32'h0);
    u_host.go(0, 6'h01, 4'h4, 32'hFFFFFFFF);
    rc(6'h01, 32'hF3A00046);
    u_host.go(0, 6'h01, 4'h8, 32'hA0000000);
    rc(6'h01, 32'h53A00046);
    u_host.go(0, 6'h01, 4'hB, 32'hFF000100);
    pulse(5'h19, 0);
    rc(6'h01, 32'h82A00100);
    u_host.go(0, 6'h00, 4'hF, 32'h0);
    u_host.go(0, 6'h14, 4'hF, 32'hFFFFFFFF);
    rc(6'h00, {`PCFH_DEVICE_BASE, 4'h8, `PCFH_VENDOR_CODE});
    foreach (tab[k]) rc(tab[k], 32'h0);
    u_host.go(0, 6'h01, 4'h1, 32'h00000006);
    sys_rst = 1;
    rev = 0;
    @(posedge clk) #1 sys_rst = 0;
    rc(6'h01, 32'h02800000);
    chk({p_en, m_en, b_en}, 3'b000);
    wrap_up;
  end
  // Hang guard
  initial begin
    repeat (2000) @(posedge clk);
    failures++;
    wrap_up;
  end
endmodule // pcfh_config_header_test
`default_nettype wire
